// ===== rtl/ebici_cfg.svh
// constants for the external bus idle cycle inserter
`ifndef EBICI_CFG_SVH
`define EBICI_CFG_SVH

// register byte offsets
`define EBICI_CTRL_OFS 12'h000
`define EBICI_STAT_OFS 12'h004
// idle_cycle_control reset: all cases on, count A = 4, count B = 4
`define EBICI_CTRL_RST 16'hFF00
// idle_cycle_control field positions
`define EBICI_SEL_LSB 0
`define EBICI_SEL_MSB 7
`define EBICI_CA_LSB 8
`define EBICI_CA_MSB 9
`define EBICI_CB_LSB 10
`define EBICI_CB_MSB 11
`define EBICI_EN_WAR 12
`define EBICI_EN_DAR 13
`define EBICI_EN_RAW 14
`define EBICI_EN_SGL 15
// largest number of dead cycles
`define EBICI_GAP_MAX 3'h4

`endif

// ===== rtl/ebici_pkg.sv
// types and count decoders for the idle cycle inserter
`include "ebici_cfg.svh"

package ebici_pkg;

    // controller states, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001, // no external cycle, none requested
        ST_WAIT = 3'b010, // request held back by dead cycles
        ST_BUSY = 3'b100  // external cycle running
    } ebici_state_t;

    // count A: 00..11 gives 1..4, never above four
    function automatic logic [2:0] ebici_cnt_a(input logic [1:0] code);
        ebici_cnt_a = {1'b0, code} + 3'h1;
    endfunction : ebici_cnt_a

    // count B: 00 gives 0, else 2..4
    function automatic logic [2:0] ebici_cnt_b(input logic [1:0] code);
        ebici_cnt_b = (code == 2'h0) ? 3'h0 : ({1'b0, code} + 3'h1);
    endfunction : ebici_cnt_b

endpackage : ebici_pkg

// ===== rtl/ebici_gap_if.sv
// carrier between the core and the dead cycle calculator
`timescale 1ns/10ps

interface ebici_gap_if;
    logic prev_valid;   // an external cycle has run since reset
    logic prev_write;   // previous cycle was a write
    logic prev_single;  // previous cycle was a single address transfer write
    logic [2:0] prev_area; // area of previous cycle
    logic next_write;   // requested cycle is a write
    logic [2:0] next_area; // area of requested cycle
    logic [15:0] ctrl;  // idle_cycle_control contents
    logic [2:0] need;   // dead cycles required

    modport core (output prev_valid, prev_write, prev_single, prev_area,
                  output next_write, next_area, ctrl, input need);
    modport calc (input prev_valid, prev_write, prev_single, prev_area,
                  input next_write, next_area, ctrl, output need);
endinterface : ebici_gap_if

// ===== rtl/ebici_gap_calc.sv
// dead cycle count for a pair of consecutive external cycles
`timescale 1ns/10ps
`include "ebici_cfg.svh"

module ebici_gap_calc
(
    ebici_gap_if.calc g // previous and next cycle, settings, result
);
    logic [7:0] sel_vec; // per_area_count_choice bits
    logic [2:0] cnt_a; // decoded count A
    logic [2:0] pick; // A or B by previous area

    // ------------------------------------------------------------
    // case selection
    // ------------------------------------------------------------
    always_comb
    begin
        sel_vec = g.ctrl[`EBICI_SEL_MSB:`EBICI_SEL_LSB];
        cnt_a = ebici_pkg::ebici_cnt_a(g.ctrl[`EBICI_CA_MSB:`EBICI_CA_LSB]);
        // choice follows the earlier cycle's area
        pick = sel_vec[g.prev_area] ?
            ebici_pkg::ebici_cnt_b(g.ctrl[`EBICI_CB_MSB:`EBICI_CB_LSB]) : cnt_a;
        g.need = 3'h0; // default: cleared enables insert nothing
        if (!g.prev_valid)
        begin
            g.need = 3'h0; // nothing on the bus yet to collide with
        end
        else if (g.prev_write)
        begin
            // single transfer wins, plain read after write otherwise
            if (g.prev_single && g.ctrl[`EBICI_EN_SGL])
            begin
                g.need = cnt_a;
            end
            else if (!g.next_write && g.ctrl[`EBICI_EN_RAW])
            begin
                g.need = cnt_a;
            end
        end
        else if (g.next_write)
        begin
            if (g.ctrl[`EBICI_EN_WAR])
            begin
                g.need = pick;
            end
        end
        else if ((g.next_area != g.prev_area) && g.ctrl[`EBICI_EN_DAR])
        begin
            g.need = pick; // same-area reads fall through to zero
        end
    end

endmodule : ebici_gap_calc

// ===== rtl/ebici_top.sv
// idle cycle inserter between consecutive external bus cycles
//
// Overview of operation
// - Dead cycles only for four sequence cases
// - Never more than four dead cycles
// - Different-area reads: gap, A or B
// - Write after read: gap, A or B
// - Read after write: gap, always A
// - Access after single transfer write: A
// - Cleared case enable suppresses that gap, but a read after a single write still gets A while read after write is on
// - Earlier cycle's area picks A or B
// - Count A codes 1,2,3,4 cycles
// - Count B codes 0,2,3,4 cycles
// - Reset: all cases on, four cycles
// - Non-external cycles count toward the gap
// - Dead cycle pins: next address, idle levels
`timescale 1ns/10ps
`include "ebici_cfg.svh"

module ebici_top
(
    input wire logic pclk, // bus clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready, no wait states
    output logic pslverr, // apb error on unmapped or read-only
    input wire logic acc_req, // external cycle requested, held
    input wire logic acc_write, // requested cycle writes
    input wire logic acc_single, // requested cycle is single transfer write
    input wire logic [2:0] acc_area, // requested cycle area
    input wire logic [23:0] acc_addr, // requested cycle address
    input wire logic acc_done, // last cycle of running external cycle
    output logic acc_grant, // requested cycle may start now
    output logic gap_active, // this cycle is a dead cycle
    output logic [23:0] ext_addr, // address pins override
    output logic ext_data_oe, // data pin drive enable
    output logic [7:0] ext_cs_n, // chip selects override
    output logic ext_rd_n, // read strobe override
    output logic ext_bs_n, // bus start override
    output logic ext_rdwr, // direction override
    output logic [1:0] ext_wr_n, // byte write strobes override
    output logic address_hold_strobe_n, // address hold strobe override
    output logic pad_gap // pad overrides apply this cycle
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ebici_gap_if gif(); // to the calculator
    ebici_pkg::ebici_state_t state_ff; // controller state
    ebici_pkg::ebici_state_t nxt_state; // next state
    logic [15:0] ctrl_ff; // idle_cycle_control
    logic prev_valid_ff; // a cycle has run since reset
    logic prev_write_ff; // last cycle wrote
    logic prev_single_ff; // last cycle was single transfer write
    logic [2:0] prev_area_ff; // last cycle area
    logic [2:0] elapsed_ff; // free cycles since last cycle ended
    logic [23:0] ext_addr_ff; // registered pad address
    logic pad_gap_ff; // registered dead cycle flag
    logic busy; // external cycle in progress
    logic wr_en; // apb write strobe
    logic rd_hit; // apb address decodes
    logic [31:0] stat_word; // status view

    // ------------------------------------------------------------
    // calculator
    // ------------------------------------------------------------
    assign gif.prev_valid = prev_valid_ff;
    assign gif.prev_write = prev_write_ff;
    assign gif.prev_single = prev_single_ff;
    assign gif.prev_area = prev_area_ff;
    assign gif.next_write = acc_write;
    assign gif.next_area = acc_area;
    assign gif.ctrl = ctrl_ff;

    ebici_gap_calc u_calc
    (
        .g (gif.calc)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // zero wait state slave; decode is shared by read and error
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_hit = (paddr == `EBICI_CTRL_OFS) || (paddr == `EBICI_STAT_OFS);

    // status: state, need, elapsed, last cycle
    assign stat_word = {17'h00000, state_ff, gif.need, elapsed_ff,
                        prev_area_ff, prev_single_ff, prev_write_ff,
                        prev_valid_ff};

    // read mux, unmapped reads zero
    always_comb
    begin
        prdata = 32'h00000000;
        if (paddr == `EBICI_CTRL_OFS)
        begin
            prdata = {16'h0000, ctrl_ff};
        end
        else if (paddr == `EBICI_STAT_OFS)
        begin
            prdata = stat_word;
        end
    end

    // error on unmapped address or write to status
    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable)
        begin
            pslverr = !rd_hit || (pwrite && (paddr == `EBICI_STAT_OFS));
        end
    end

    // control register; a change steers only later decisions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= `EBICI_CTRL_RST;
        end
        else if (wr_en && (paddr == `EBICI_CTRL_OFS))
        begin
            ctrl_ff <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    assign busy = (state_ff == ebici_pkg::ST_BUSY);
    // free cycles already spent cover part of the gap
    assign acc_grant = acc_req && !busy && (elapsed_ff >= gif.need);
    assign gap_active = acc_req && !busy && !acc_grant;

    // next state
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ebici_pkg::ST_IDLE:
            begin
                if (acc_grant)
                begin
                    nxt_state = ebici_pkg::ST_BUSY;
                end
                else if (acc_req)
                begin
                    nxt_state = ebici_pkg::ST_WAIT;
                end
            end
            ebici_pkg::ST_WAIT:
            begin
                if (acc_grant)
                begin
                    nxt_state = ebici_pkg::ST_BUSY;
                end
                else if (!acc_req)
                begin
                    nxt_state = ebici_pkg::ST_IDLE; // request withdrawn
                end
            end
            ebici_pkg::ST_BUSY:
            begin
                if (acc_done)
                begin
                    nxt_state = ebici_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ebici_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ebici_pkg::ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // free cycle counter, saturates at the largest gap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            elapsed_ff <= 3'h0;
        end
        else if (busy || acc_grant)
        begin
            elapsed_ff <= 3'h0; // restarts after every external cycle
        end
        else if (elapsed_ff < `EBICI_GAP_MAX)
        begin
            elapsed_ff <= elapsed_ff + 3'h1;
        end
    end

    // remember the started cycle for the next decision
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_valid_ff <= 1'b0;
            prev_write_ff <= 1'b0;
            prev_single_ff <= 1'b0;
            prev_area_ff <= 3'h0;
        end
        else if (acc_grant)
        begin
            prev_valid_ff <= 1'b1;
            prev_write_ff <= acc_write | acc_single; // single is a write
            prev_single_ff <= acc_single;
            prev_area_ff <= acc_area;
        end
    end

    // ------------------------------------------------------------
    // pad overrides
    // ------------------------------------------------------------
    // one pad register stage; levels show the cycle after the decision
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_gap_ff <= 1'b0;
            ext_addr_ff <= 24'h000000;
        end
        else
        begin
            pad_gap_ff <= gap_active;
            if (gap_active)
            begin
                ext_addr_ff <= acc_addr; // next cycle's address
            end
        end
    end

    // idle levels; only the address hold strobe and the address pins move
    assign pad_gap = pad_gap_ff;
    assign ext_addr = ext_addr_ff;
    assign ext_data_oe = 1'b0; // data pins float
    assign ext_cs_n = 8'hFF;
    assign ext_rd_n = 1'b1;
    assign ext_bs_n = 1'b1;
    assign ext_rdwr = 1'b1;
    assign ext_wr_n = 2'h3;
    assign address_hold_strobe_n = !pad_gap_ff; // low in dead cycle

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic chk_rd_rd; // different-area read pair pending
    logic chk_war; // write after read pending
    logic [2:0] chk_a; // decoded count A
    logic [2:0] chk_pick; // decoded A or B by earlier area
    assign chk_a = ebici_pkg::ebici_cnt_a(ctrl_ff[`EBICI_CA_MSB:`EBICI_CA_LSB]);
    assign chk_pick = ctrl_ff[`EBICI_SEL_LSB + prev_area_ff] ?
        ebici_pkg::ebici_cnt_b(ctrl_ff[`EBICI_CB_MSB:`EBICI_CB_LSB]) : chk_a;
    assign chk_rd_rd = prev_valid_ff && !prev_write_ff && !acc_write
        && (acc_area != prev_area_ff);
    assign chk_war = prev_valid_ff && !prev_write_ff && acc_write;

    sequence s_wait;
        gap_active;
    endsequence

    sequence s_pads_idle;
        !address_hold_strobe_n && pad_gap && (ext_cs_n == 8'hFF)
            && !ext_data_oe && (ext_addr == $past(acc_addr));
    endsequence

    property p_cap;
        @(posedge pclk) disable iff (!presetn)
        acc_req |-> (gif.need <= `EBICI_GAP_MAX);
    endproperty
    a_cap: assert property (p_cap) else $error("gap above four");

    property p_rd_rd;
        @(posedge pclk) disable iff (!presetn)
        (chk_rd_rd && ctrl_ff[`EBICI_EN_DAR]) |-> (gif.need == chk_pick);
    endproperty
    a_rd_rd: assert property (p_rd_rd) else $error("read pair gap");

    property p_war;
        @(posedge pclk) disable iff (!presetn)
        (chk_war && ctrl_ff[`EBICI_EN_WAR]) |-> (gif.need == chk_pick);
    endproperty
    a_war: assert property (p_war) else $error("write after read gap");

    property p_raw;
        @(posedge pclk) disable iff (!presetn)
        (prev_valid_ff && prev_write_ff && !prev_single_ff && !acc_write
            && ctrl_ff[`EBICI_EN_RAW]) |-> (gif.need == chk_a);
    endproperty
    a_raw: assert property (p_raw) else $error("read after write gap");

    property p_single;
        @(posedge pclk) disable iff (!presetn)
        (prev_valid_ff && prev_single_ff && ctrl_ff[`EBICI_EN_SGL])
            |-> (gif.need == chk_a);
    endproperty
    a_single: assert property (p_single) else $error("single gap");

    property p_off;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_ff[`EBICI_EN_SGL:`EBICI_EN_WAR] == 4'h0) |-> (gif.need == 3'h0);
    endproperty
    a_off: assert property (p_off) else $error("gap while disabled");

    property p_cnt_a;
        @(posedge pclk) disable iff (!presetn)
        (((chk_rd_rd && ctrl_ff[`EBICI_EN_DAR]) || (chk_war && ctrl_ff[`EBICI_EN_WAR]))
            && !ctrl_ff[`EBICI_SEL_LSB + prev_area_ff]
            && (ctrl_ff[`EBICI_CA_MSB:`EBICI_CA_LSB] == 2'h0)) |-> (gif.need == 3'h1);
    endproperty
    a_cnt_a: assert property (p_cnt_a) else $error("count A code 00");

    property p_cnt_b;
        @(posedge pclk) disable iff (!presetn)
        (((chk_rd_rd && ctrl_ff[`EBICI_EN_DAR]) || (chk_war && ctrl_ff[`EBICI_EN_WAR]))
            && ctrl_ff[`EBICI_SEL_LSB + prev_area_ff]
            && (ctrl_ff[`EBICI_CB_MSB:`EBICI_CB_LSB] == 2'h0)) |-> (gif.need == 3'h0);
    endproperty
    a_cnt_b: assert property (p_cnt_b) else $error("count B code 00");

    property p_rst;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (ctrl_ff == `EBICI_CTRL_RST);
    endproperty
    a_rst: assert property (p_rst) else $error("control reset value");

    property p_nop;
        @(posedge pclk) disable iff (!presetn)
        (!busy && !acc_grant && (elapsed_ff < `EBICI_GAP_MAX))
            |=> (elapsed_ff == $past(elapsed_ff) + 3'h1);
    endproperty
    a_nop: assert property (p_nop) else $error("free cycles miscounted");

    property p_pads;
        @(posedge pclk) disable iff (!presetn)
        s_wait |=> s_pads_idle;
    endproperty
    a_pads: assert property (p_pads) else $error("dead cycle pad levels");

    property p_same;
        @(posedge pclk) disable iff (!presetn)
        (prev_valid_ff && !prev_write_ff && !acc_write && (acc_area == prev_area_ff))
            |-> (gif.need == 3'h0);
    endproperty
    a_same: assert property (p_same) else $error("gap on same area reads");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        acc_grant |=> busy ##0 (elapsed_ff == 3'h0);
    endproperty
    a_start: assert property (p_start) else $error("grant did not start");

endmodule : ebici_top

// ===== test/ebici_dev_model.sv
// behavioural model of the external device side: length of each bus cycle
`timescale 1ns/10ps

module ebici_dev_model
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic acc_grant, // external cycle starts this cycle
    input wire logic [3:0] cyc_len, // cycles after grant, at least 1
    output logic acc_done // last cycle of the running external cycle
);
    logic [3:0] left_ff; // cycles still to run

    // ------------------------------------------------------------
    // cycle length counter
    // ------------------------------------------------------------
    // a long cyc_len stands for a slow device; done is a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            left_ff <= 4'h0;
        else if (acc_grant)
            left_ff <= cyc_len; // new cycle loads its length
        else if (left_ff != 4'h0)
            left_ff <= left_ff - 4'h1; // count down while running
    end

    assign acc_done = (left_ff == 4'h1); // last running cycle
endmodule : ebici_dev_model

// ===== test/testbench.sv
// self-checking bench for the idle cycle inserter
`timescale 1ns/10ps
`include "ebici_cfg.svh"

module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk = 1'b0; // 100 MHz
    logic presetn = 1'b0; // held low for four cycles
    logic psel = 1'b0; // apb master outputs
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata; // apb slave outputs
    logic pready;
    logic pslverr;
    logic acc_req = 1'b0; // access request side
    logic acc_write = 1'b0;
    logic acc_single = 1'b0;
    logic [2:0] acc_area = 3'h0;
    logic [23:0] acc_addr = 24'h0;
    logic acc_done; // from the device model
    logic acc_grant;
    logic gap_active;
    logic [23:0] ext_addr; // pad overrides
    logic ext_data_oe;
    logic [7:0] ext_cs_n;
    logic ext_rd_n;
    logic ext_bs_n;
    logic ext_rdwr;
    logic [1:0] ext_wr_n;
    logic address_hold_strobe_n;
    logic pad_gap;
    logic [3:0] cyc_len = 4'h1; // device cycle length
    int n_errors = 0; // mismatches
    int n_compared = 0; // comparisons
    // per-case tables: read-read, write-after-read, read-after-write, after single
    localparam int EN_POS [4] = '{13, 12, 14, 15};
    localparam int EXP_ON [4] = '{4, 4, 2, 2};
    localparam logic [3:0] W1 = 4'b1100; // first cycle writes
    localparam logic [3:0] S1 = 4'b1000; // first cycle is single transfer write
    localparam logic [3:0] W2 = 4'b1010; // second cycle writes

    always #5 pclk = ~pclk; // 10 ns period

    ebici_top uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_req(acc_req), .acc_write(acc_write), .acc_single(acc_single),
        .acc_area(acc_area), .acc_addr(acc_addr), .acc_done(acc_done),
        .acc_grant(acc_grant), .gap_active(gap_active), .ext_addr(ext_addr),
        .ext_data_oe(ext_data_oe), .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n),
        .ext_bs_n(ext_bs_n), .ext_rdwr(ext_rdwr), .ext_wr_n(ext_wr_n),
        .address_hold_strobe_n(address_hold_strobe_n), .pad_gap(pad_gap)
    );

    ebici_dev_model dev
    (
        .pclk(pclk), .presetn(presetn), .acc_grant(acc_grant), .cyc_len(cyc_len),
        .acc_done(acc_done)
    );

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // a wait that ran out counts as a mismatch
    task automatic tmo();
        n_errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        end_sim();
    endtask : tmo

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    // ------------------------------------------------------------
    // apb transfer: setup, access until pready at a rising edge
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata; // taken at the completing edge only
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
            tmo();
    endtask : apb

    // ------------------------------------------------------------
    // one external access: nop idle cycles, then request until grant
    // ------------------------------------------------------------
    // entered right after the edge that ends the previous done cycle, so
    // idle cycles before the request count from zero; exp < 0 skips the count
    task automatic acc(input logic w, input logic s, input logic [2:0] ar, input int nop,
                       input int exp, input string what);
        int i;
        int gaps;
        int pads;
        logic [23:0] ad;
        ad = {ar, 21'h0A5A5};
        gaps = 0;
        pads = 0;
        repeat (nop) @(posedge pclk);
        acc_req <= 1'b1;
        acc_write <= w;
        acc_single <= s;
        acc_area <= ar;
        acc_addr <= ad;
        for (i = 0; i < 40; i++)
        begin
            @(negedge pclk);
            if (pad_gap === 1'b1) // pins idle, next address out
            begin
                pads++;
                chk({address_hold_strobe_n, ext_data_oe, ext_cs_n, ext_rd_n, ext_bs_n,
                     ext_rdwr, ext_wr_n, ext_addr}, {10'h0FF, 5'h1F, ad}, "dead pins");
            end
            if (acc_grant === 1'b1)
                break;
            if (gap_active === 1'b1)
                gaps++;
            @(posedge pclk);
        end
        if (i == 40)
            tmo();
        @(posedge pclk);
        acc_req <= 1'b0;
        // pad stage lags one cycle, so its count matches the dead cycles
        chk(40'(pads), 40'(gaps), "dead pin cycles");
        if (exp >= 0)
            chk(40'(gaps), 40'(exp), what);
        for (i = 0; i < 40; i++)
        begin
            @(negedge pclk);
            if (acc_done === 1'b1)
                break;
        end
        if (i == 40)
            tmo();
        @(posedge pclk);
    endtask : acc

    // settings, then two back-to-back accesses with the second one counted
    task automatic pair(input logic [15:0] ctl, input logic w1, input logic s1,
                        input logic [2:0] a1, input logic w2, input logic [2:0] a2,
                        input int exp, input string what);
        logic [31:0] rd;
        logic err;
        apb(1'b1, `EBICI_CTRL_OFS, {16'h0, ctl}, rd, err);
        acc(w1, s1, a1, 0, -1, "first");
        acc(w2, 1'b0, a2, 0, exp, what);
    endtask : pair

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] rd;
        logic err;
        logic [15:0] en;
        int c;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `EBICI_CTRL_OFS, 32'h0, rd, err);
        chk({7'h0, err, rd}, 40'h000000FF00, "ctrl reset");
        // reset settings: every case on, four cycles
        acc(1'b0, 1'b0, 3'h0, 0, -1, "first read");
        acc(1'b0, 1'b0, 3'h0, 0, 0, "same area reads");
        acc(1'b0, 1'b0, 3'h1, 0, 4, "diff area reads");
        acc(1'b1, 1'b0, 3'h1, 0, 4, "write after read");
        acc(1'b0, 1'b0, 3'h2, 0, 4, "read after write");
        acc(1'b0, 1'b0, 3'h3, 2, 2, "nop cycles counted");
        acc(1'b0, 1'b0, 3'h4, 6, 0, "nop cycles cover gap");
        cyc_len <= 4'h5; // slow device from here on
        acc(1'b1, 1'b1, 3'h4, 0, -1, "single write");
        acc(1'b1, 1'b0, 3'h5, 0, 4, "after single write");
        // register access: read-only status and an unmapped place
        apb(1'b1, `EBICI_STAT_OFS, 32'h0, rd, err);
        chk({39'h0, err}, 40'h1, "status write refused");
        apb(1'b0, 12'h008, 32'h0, rd, err);
        chk({7'h0, err, rd}, 40'h0100000000, "unmapped read");
        apb(1'b1, `EBICI_CTRL_OFS, 32'hFFFF5A3C, rd, err);
        apb(1'b0, `EBICI_CTRL_OFS, 32'h0, rd, err);
        chk({7'h0, err, rd}, 40'h0000005A3C, "ctrl readback");
        // count codes; area 4 picks B, the earlier area decides
        for (c = 0; c < 4; c++)
        begin
            en = {4'hF, c[1:0], 2'(3 - c), 8'h10};
            pair(en, 1'b0, 1'b0, 3'h3, 1'b0, 3'h4, 4 - c, "count A");
            pair(en, 1'b0, 1'b0, 3'h4, 1'b0, 3'h3, (c == 0) ? 0 : c + 1, "count B");
        end
        // each case alone on, then alone off; A = 2, B = 4, all areas pick B
        for (c = 0; c < 4; c++)
        begin
            en = 16'h0DFF | (16'h1 << EN_POS[c]);
            pair(en, W1[c], S1[c], 3'h1, W2[c], 3'h2, EXP_ON[c], "case on");
            en = 16'hFDFF & ~(16'h1 << EN_POS[c]);
            pair(en, W1[c], S1[c], 3'h1, W2[c], 3'h2, 0, "case off");
        end
        // every case off at once, largest counts still set
        pair(16'h0FFF, 1'b1, 1'b0, 3'h1, 1'b0, 3'h2, 0, "all cases off");
        end_sim();
    end
endmodule : testbench
